// ===== verilog/mcl_core.sv
// Motor current limiting and stall detection with AXI4-Lite registers
`include "mcl_defs.svh"
`default_nettype none
module mcl_core
    import mcl_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Bridge control pins and sensing
    input  wire logic        bridge_in_a,
    input  wire logic        bridge_in_b,
    input  wire logic        cmp_ext_ref,
    input  wire logic        cmp_int_ref,
    input  wire logic        sleep_exit,
    input  wire logic        fault_recover,
    // Bridge drive: per half-bridge high and low switch
    output logic [1:0]       bridge_outputs_hi,
    output logic [1:0]       bridge_outputs_lo,
    // Open-drain fault pin
    output logic             fault_out_n_o,
    output logic             fault_out_n_oe
);
    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [15:0] blank;
        mcl_reg_t    mode;
        logic [15:0] off_cnt;
        logic        blocked;
        logic        chop_ind;
        logic [1:0]  pin_q;
        logic [1:0]  hi;
        logic [1:0]  lo;
        logic        fault_oe;
    } mcl_st_t;
    mcl_st_t     st, next_st;
    logic        trip;
    logic        blank_active;
    logic        restart;
    logic [1:0]  in_cmd;
    logic        pin_edge;
    logic        reg_rise;
    logic        reg_change;
    logic        wr_fire;
    logic        wr_ctrl;
    logic [31:0] new_ctrl;
    logic        reg_on;
    logic        stall_now;
    logic [1:0]  cmd_hi;
    logic [1:0]  cmd_lo;
    logic        stall_en;
    mcl_trip u_trip
    (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .cmp_ext_ref            (cmp_ext_ref),
        .cmp_int_ref            (cmp_int_ref),
        .internal_threshold_sel (st.ctrl[`MCL_B_INT_THR]),
        .trip                   (trip)
    );
    mcl_blank u_blank
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .restart     (restart),
        .blank_steps (st.blank),
        .setpoint    (st.ctrl[31:`MCL_B_SETPOINT]),
        .softstart   (st.ctrl[`MCL_B_SOFTSTART]),
        .active      (blank_active)
    );
    assign wr_fire  = st.aw_got && st.w_got && !st.bvalid;
    assign wr_ctrl  = wr_fire && st.aw_addr == `MCL_ADDR_CTRL;
    assign stall_en = st.ctrl[`MCL_B_STALL_EN];
    // Restart on fault clear, sleep exit or fault recovery
    assign restart = (wr_ctrl && st.w_strb[1] && st.w_data[`MCL_B_CLEAR]) || sleep_exit || fault_recover;
    always_comb
    begin
        new_ctrl = st.ctrl;
        for (int i = 0; i < 4; i++)
            if (st.w_strb[i])
                new_ctrl[i*8 +: 8] = st.w_data[i*8 +: 8];
        new_ctrl[`MCL_B_CLEAR] = 1'b0;
    end
    // Pins and register bits combine; either side commands the bridge
    assign in_cmd     = {bridge_in_b | st.ctrl[`MCL_B_IN_B], bridge_in_a | st.ctrl[`MCL_B_IN_A]};
    assign pin_edge   = ({bridge_in_b, bridge_in_a} != st.pin_q);
    assign reg_rise   = wr_ctrl && |(new_ctrl[1:0] & ~st.ctrl[1:0]);
    assign reg_change = wr_ctrl && (new_ctrl[1:0] != st.ctrl[1:0]);
    // Regulation enable by policy
    always_comb
    begin
        unique case (st.ctrl[`MCL_B_POLICY +: 2])
            2'b00:   reg_on = 1'b0;
            2'b01:   reg_on = stall_en ? blank_active : 1'b1;
            default: reg_on = 1'b1;
        endcase
    end
    assign stall_now = stall_en && !blank_active && trip;
    // Commanded drive from the inputs
    always_comb
    begin
        unique case (in_cmd)
            2'b01:   begin cmd_hi = 2'b01; cmd_lo = 2'b10; end
            2'b10:   begin cmd_hi = 2'b10; cmd_lo = 2'b01; end
            2'b11:   begin cmd_hi = 2'b00; cmd_lo = 2'b11; end
            default: begin cmd_hi = 2'b00; cmd_lo = 2'b00; end
        endcase
    end
    always_comb
    begin
        next_st = st;
        next_st.pin_q = {bridge_in_b, bridge_in_a};
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_got = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        if (wr_fire)
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp = 2'b00;
            if (st.aw_addr == `MCL_ADDR_CTRL)
                next_st.ctrl = new_ctrl;
            else if (st.aw_addr == `MCL_ADDR_BLANK)
            begin
                if (st.w_strb[0])
                    next_st.blank[7:0] = st.w_data[7:0];
                if (st.w_strb[1])
                    next_st.blank[15:8] = st.w_data[15:8];
            end
            else if (st.aw_addr != `MCL_ADDR_STATUS)
                next_st.bresp = 2'b10;
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        // Read channel
        if (s_axi_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = 2'b00;
            unique case (s_axi_araddr)
                `MCL_ADDR_CTRL:   next_st.rdata = st.ctrl;
                `MCL_ADDR_BLANK:  next_st.rdata = {16'h0, st.blank};
                `MCL_ADDR_STATUS: next_st.rdata = {26'h0, st.mode, blank_active, trip, st.chop_ind, st.blocked};
                default:
                begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = 2'b10;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        // Stall flag: detection wins over a clear in the same cycle
        if (restart && !(wr_ctrl && st.w_data[`MCL_B_CLEAR] == 1'b0))
            next_st.blocked = 1'b0;
        if (stall_now)
            next_st.blocked = 1'b1;
        // Regulation state machine
        unique case (st.mode)
            MCL_FOLLOW:
                if (reg_on && trip && st.ctrl[`MCL_B_SCHEME +: 2] == 2'b00)
                begin
                    next_st.mode = MCL_FIXED_OFF;
                    next_st.off_cnt = 16'(`MCL_OFF_CYC - 1);
                end
                else if (reg_on && trip && st.ctrl[`MCL_B_SCHEME +: 2] == 2'b01)
                begin
                    next_st.mode = MCL_CBC_HOLD;
                    next_st.chop_ind = st.ctrl[`MCL_B_CHOP_TO_FAULT_PIN] && (^in_cmd);
                end
            MCL_FIXED_OFF:
                if (pin_edge || reg_change)
                    next_st.mode = MCL_FOLLOW;
                else if (st.off_cnt != 16'h0)
                    next_st.off_cnt = st.off_cnt - 16'h1;
                else if (trip && reg_on)
                    next_st.off_cnt = 16'(`MCL_OFF_CYC - 1);
                else
                    next_st.mode = MCL_FOLLOW;
            MCL_CBC_HOLD:
                if (pin_edge || reg_rise)
                begin
                    next_st.mode = MCL_FOLLOW;
                    next_st.chop_ind = 1'b0;
                end
        endcase
        // Bridge drive
        if (st.blocked && !st.ctrl[`MCL_B_RESP])
        begin
            next_st.hi = 2'b00;
            next_st.lo = 2'b00;
        end
        else if (next_st.mode != MCL_FOLLOW)
        begin
            next_st.hi = 2'b00;
            next_st.lo = 2'b11;
        end
        else
        begin
            next_st.hi = cmd_hi;
            next_st.lo = cmd_lo;
        end
        // Fault pin only reports; it never feeds back into drive
        // Chop report masked outside forward or reverse, so it never looks like a fault
        next_st.fault_oe = (next_st.chop_ind && st.ctrl[`MCL_B_CHOP_TO_FAULT_PIN] && (^in_cmd))
                           || (next_st.blocked && st.ctrl[`MCL_B_BLOCKED_TO_FAULT_PIN]);
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.ctrl <= `MCL_CTRL_RST;
            st.blank <= `MCL_BLANK_RST;
            st.mode <= MCL_FOLLOW;
        end
        else
            st <= next_st;
    end
    assign s_axi_awready     = st.awready;
    assign s_axi_wready      = st.wready;
    assign s_axi_bvalid      = st.bvalid;
    assign s_axi_bresp       = st.bresp;
    assign s_axi_arready     = st.arready;
    assign s_axi_rvalid      = st.rvalid;
    assign s_axi_rdata       = st.rdata;
    assign s_axi_rresp       = st.rresp;
    assign bridge_outputs_hi = st.hi;
    assign bridge_outputs_lo = st.lo;
    assign fault_out_n_o     = 1'b0;
    assign fault_out_n_oe    = st.fault_oe;
    AST_FIXED_BRAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == MCL_FIXED_OFF && !$past(st.blocked && !st.ctrl[`MCL_B_RESP]) |-> st.lo == 2'b11 && st.hi == 2'b00)
        else $error("fixed off-time not braking");
    AST_INPUT_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == MCL_FIXED_OFF && pin_edge |=> st.mode == MCL_FOLLOW)
        else $error("input change did not end off time");
    AST_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == MCL_FIXED_OFF && st.off_cnt == 16'h0 && !trip && !pin_edge && !reg_change
        |=> st.mode == MCL_FOLLOW)
        else $error("fixed off-time did not rearm");
    AST_CBC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        st.mode == MCL_CBC_HOLD && !pin_edge && !reg_rise |=> st.mode == MCL_CBC_HOLD)
        else $error("cycle-by-cycle hold left early");
    AST_CHOP_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st.chop_ind) |-> $past(^in_cmd))
        else $error("chop indication outside drive command");
    AST_STALL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        stall_now |=> st.blocked)
        else $error("stall not flagged");
    AST_NO_BLANK_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
        blank_active && !restart && !st.blocked |=> !st.blocked)
        else $error("stall flagged inside blanking");
    AST_LATCH_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        st.blocked && !st.ctrl[`MCL_B_RESP] |=> st.hi == 2'b00 && st.lo == 2'b00)
        else $error("outputs drive after latched stall");
    AST_STALL_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
        st.blocked && st.ctrl[`MCL_B_BLOCKED_TO_FAULT_PIN] && $stable(st.ctrl) |=> fault_out_n_oe || !st.blocked)
        else $error("stall not reported on fault pin");
endmodule
`default_nettype wire

// ===== verilog/mcl_defs.svh
// Constants for the motor current limit and stall block
`ifndef MCL_DEFS_SVH
`define MCL_DEFS_SVH
`define MCL_CLK_HZ          40000000
`define MCL_STEP_NS         102400
`define MCL_STEP_CYC        ((`MCL_STEP_NS * 40) / 1000)
`define MCL_BASE_MS         5
`define MCL_BASE_CYC        (`MCL_BASE_MS * (`MCL_CLK_HZ / 1000))
`define MCL_OFF_TIME_NS     25000
`define MCL_OFF_CYC         ((`MCL_OFF_TIME_NS * 40 + 999) / 1000)
`define MCL_ADDR_CTRL       4'h0
`define MCL_ADDR_BLANK      4'h4
`define MCL_ADDR_STATUS     4'h8
`define MCL_BLANK_RST       16'h2585
`define MCL_CTRL_RST        32'h0000_0110
`define MCL_B_IN_A          0
`define MCL_B_IN_B          1
`define MCL_B_POLICY        2
`define MCL_B_SCHEME        4
`define MCL_B_STALL_EN      8
`define MCL_B_RESP          9
`define MCL_B_CHOP_TO_FAULT_PIN       10
`define MCL_B_BLOCKED_TO_FAULT_PIN     11
`define MCL_B_INT_THR       12
`define MCL_B_SOFTSTART     13
`define MCL_B_CLEAR         14
`define MCL_B_SETPOINT      16
`endif

// ===== verilog/mcl_pkg.sv
// Types for the motor current limit and stall block
`default_nettype none
package mcl_pkg;
    typedef enum logic [1:0] {MCL_FOLLOW, MCL_FIXED_OFF, MCL_CBC_HOLD} mcl_reg_t;
endpackage
`default_nettype wire

// ===== verilog/mcl_trip.sv
// Trip qualifier selecting the threshold source
`default_nettype none
module mcl_trip
    import mcl_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Comparator inputs
    input  wire logic cmp_ext_ref,
    input  wire logic cmp_int_ref,
    input  wire logic internal_threshold_sel,
    // Qualified trip
    output logic      trip
);
    typedef struct packed { logic trip; } mcl_trip_st_t;
    mcl_trip_st_t st, next_st;
    always_comb
    begin
        next_st = st;
        next_st.trip = internal_threshold_sel ? cmp_int_ref : cmp_ext_ref;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end
    assign trip = st.trip;
    AST_THR_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 trip == $past(internal_threshold_sel ? cmp_int_ref : cmp_ext_ref))
        else $error("trip does not follow selected threshold");
endmodule
`default_nettype wire

// ===== verilog/mcl_blank.sv
// Start-up blanking window timer
`include "mcl_defs.svh"
`default_nettype none
module mcl_blank
    import mcl_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Control
    input  wire logic        restart,
    input  wire logic [15:0] blank_steps,
    input  wire logic [15:0] setpoint,
    input  wire logic        softstart,
    // Status
    output logic             active
);
    typedef struct packed
    {
        logic        active;
        logic [31:0] base;
        logic [15:0] pre;
        logic [31:0] steps;
    } mcl_blank_st_t;
    mcl_blank_st_t st, next_st;
    logic [31:0] target;
    always_comb
    begin
        // Soft-start multiplies the step count by the setpoint
        target = softstart ? 32'(blank_steps) * 32'(setpoint) : 32'(blank_steps);
        next_st = st;
        if (restart)
        begin
            next_st = '0;
            next_st.active = 1'b1;
        end
        else if (st.active)
        begin
            if (st.base < 32'(`MCL_BASE_CYC - 1))
                next_st.base = st.base + 32'h1;
            else if (st.steps >= target)
                next_st.active = 1'b0;
            else if (st.pre < 16'(`MCL_STEP_CYC - 1))
                next_st.pre = st.pre + 16'h1;
            else
            begin
                next_st.pre = '0;
                next_st.steps = st.steps + 32'h1;
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '{active: 1'b1, default: '0};
        else
            st <= next_st;
    end
    assign active = st.active;
    AST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
        restart |=> active [*2])
        else $error("blank window not restarted");
endmodule
`default_nettype wire

// ===== test/mcl_host.sv
// Host controller model: AXI4-Lite master and bridge control pins
`default_nettype none
module mcl_host
    import mcl_pkg::*;
(
    // Clock
    input  wire logic        aclk,
    // AXI4-Lite write
    output var  logic [3:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // AXI4-Lite read
    output var  logic [3:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready,
    // Bridge control pins
    output var  logic        bridge_in_a,
    output var  logic        bridge_in_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, bridge_in_a, bridge_in_b} = '0;
    end
    // Released payload shows the inverse, so a stale address never looks valid
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (!w_done && s_axi_wready)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
        end
        while (!s_axi_bvalid)
            @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pins(input logic a, input logic b);
        @(posedge aclk);
        bridge_in_a <= a;
        bridge_in_b <= b;
    endtask
endmodule
`default_nettype wire

// ===== test/motor_current_limit_and_stall_bench.sv
// Self-checking bench for the motor current limit and stall block
`include "mcl_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module motor_current_limit_and_stall_bench
    import mcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] FWD = 4'h6, REV = 4'h9, BRK = 4'h3, OFF = 4'h0;
    // Stall case alone needs a 5 ms window
    localparam int         LIMIT = 300000;
    logic        aclk = 1'b0, aresetn = 1'b0, cmp_ext_ref = 1'b0, cmp_int_ref = 1'b0;
    logic        sleep_exit = 1'b0, fault_recover = 1'b0;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, bridge_outputs_hi, bridge_outputs_lo;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        bridge_in_a, bridge_in_b, fault_out_n_o, fault_out_n_oe;
    int          mismatches = 0, checks = 0, cycles = 0;
    wire logic [3:0] outs = {bridge_outputs_hi, bridge_outputs_lo};
    mcl_core DUT (.*);
    mcl_host u_host (.*);
    always #12.5 aclk = ~aclk;
    function automatic logic [31:0] cw(logic [1:0] pol, logic [1:0] sch, logic [7:0] f, logic [1:0] r);
        return {16'h0000, f, 2'b00, sch, pol, r};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic trip(input logic v);
        @(posedge aclk);
        cmp_ext_ref <= v;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        u_host.wr(a, d, resp);
        `CHK("bresp", 2'b00, resp)
    endtask
    // Waits for a drive pattern, bounded
    task automatic see(input string nm, input logic [3:0] e, input int n);
        int i;
        i = 0;
        #1;
        while (i < n && outs !== e)
        begin
            tick(1);
            i++;
        end
        `CHK(nm, e, outs)
    endtask
    // Drive pattern must not move for n cycles
    task automatic hold(input string nm, input logic [3:0] e, input int n);
        int i;
        i = 0;
        #1;
        while (i < n && outs === e)
        begin
            tick(1);
            i++;
        end
        `CHK(nm, e, outs)
    endtask
    task automatic t_regs;
        u_host.rd(`MCL_ADDR_CTRL, rd_data, resp);
        `CHK("ctrl reset", `MCL_CTRL_RST, rd_data)
        u_host.rd(`MCL_ADDR_BLANK, rd_data, resp);
        `CHK("blank reset", {16'h0000, `MCL_BLANK_RST}, rd_data)
        u_host.rd(`MCL_ADDR_STATUS, rd_data, resp);
        `CHK("blanking at power-up", 1'b1, rd_data[3])
        u_host.rd(4'hc, rd_data, resp);
        `CHK("unmapped read", 2'b10, resp)
        u_host.wr(4'hc, 32'hffff_ffff, resp);
        `CHK("unmapped write", 2'b10, resp)
        wr(`MCL_ADDR_BLANK, 32'h0000_0000);
    endtask
    task automatic t_fixed;
        wr(`MCL_ADDR_CTRL, cw(2'b10, 2'b00, 8'h00, 2'b00));
        u_host.pins(1'b1, 1'b0);
        see("forward", FWD, 8);
        trip(1'b1);
        see("brake on trip", BRK, 4);
        trip(1'b0);
        hold("off time", BRK, 990);
        see("rearm without edge", FWD, 20);
        trip(1'b1);
        see("brake again", BRK, 4);
        hold("still tripped", BRK, 1100);
        trip(1'b0);
        u_host.pins(1'b0, 1'b1);
        see("abort on edge", REV, 4);
    endtask
    task automatic t_policy;
        u_host.pins(1'b0, 1'b0);
        for (int p = 0; p < 4; p++)
        begin
            wr(`MCL_ADDR_CTRL, cw(2'(p), 2'b00, 8'h00, 2'b01));
            trip(1'b1);
            tick(6);
            `CHK("policy", (p == 0) ? FWD : BRK, outs)
            trip(1'b0);
            tick(1010);
        end
        wr(`MCL_ADDR_CTRL, cw(2'b10, 2'b00, 8'h10, 2'b01));
        trip(1'b1);
        hold("external ignored", FWD, 8);
        @(posedge aclk);
        cmp_int_ref <= 1'b1;
        see("internal threshold", BRK, 4);
        @(posedge aclk);
        cmp_ext_ref <= 1'b0;
        cmp_int_ref <= 1'b0;
        tick(1010);
    endtask
    task automatic t_cbc;
        u_host.pins(1'b1, 1'b0);
        wr(`MCL_ADDR_CTRL, cw(2'b10, 2'b01, 8'h04, 2'b00));
        see("forward", FWD, 8);
        trip(1'b1);
        trip(1'b0);
        see("cbc brake", BRK, 4);
        hold("cbc hold", BRK, 1500);
        `CHK("chop report", 1'b1, fault_out_n_oe)
        u_host.pins(1'b0, 1'b0);
        see("pin edge release", OFF, 4);
        tick(2);
        `CHK("chop released on coast", 1'b0, fault_out_n_oe)
        wr(`MCL_ADDR_CTRL, cw(2'b10, 2'b01, 8'h04, 2'b01));
        see("register forward", FWD, 8);
        trip(1'b1);
        trip(1'b0);
        see("cbc brake register", BRK, 4);
        wr(`MCL_ADDR_CTRL, cw(2'b10, 2'b01, 8'h04, 2'b10));
        see("rising bit release", REV, 4);
        tick(2);
        `CHK("chop released", 1'b0, fault_out_n_oe)
    endtask
    task automatic t_stall;
        int i;
        u_host.pins(1'b0, 1'b0);
        wr(`MCL_ADDR_CTRL, cw(2'b00, 2'b00, 8'h09, 2'b01));
        // Sleep exit alone must re-arm the window; the checks land after the power-up window would have closed
        @(posedge aclk);
        sleep_exit <= 1'b1;
        @(posedge aclk);
        sleep_exit <= 1'b0;
        trip(1'b1);
        tick(199000);
        u_host.rd(`MCL_ADDR_STATUS, rd_data, resp);
        `CHK("blanked trip", 1'b0, rd_data[0])
        `CHK("drive in window", FWD, outs)
        i = 0;
        while (i < 1100 && fault_out_n_oe !== 1'b1)
        begin
            tick(1);
            i++;
        end
        u_host.rd(`MCL_ADDR_STATUS, rd_data, resp);
        `CHK("stall flag", 1'b1, rd_data[0])
        `CHK("window expired", 1'b0, rd_data[3])
        `CHK("stall disables", OFF, outs)
        `CHK("stall report", 1'b1, fault_out_n_oe)
        trip(1'b0);
        wr(`MCL_ADDR_CTRL, cw(2'b00, 2'b00, 8'h49, 2'b01));
        u_host.rd(`MCL_ADDR_STATUS, rd_data, resp);
        `CHK("flag cleared", 1'b0, rd_data[0])
        `CHK("window restarted", 1'b1, rd_data[3])
        `CHK("report released", 1'b0, fault_out_n_oe)
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fixed();
        t_policy();
        t_cbc();
        t_stall();
        end_of_test();
    end
endmodule
`default_nettype wire
